// ==== sgp_host_model.sv ====
// host bus master: start, stop, byte writes and reads
// assumes sda is the resolved wire with a pull-up
`timescale 1ns/1ps
module sgp_host_model (
   input wire logic sys_clk,
   input wire logic sda,
   output logic scl,
   output logic sda_drv
);
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic hw(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   // six cycles a phase covers the device's sync lag
   task automatic bit_x(input logic b, output logic r);
      hw(1);
      sda_drv = b;
      hw(5);
      scl = 1'b1;
      hw(6);
      r = sda;
      scl = 1'b0;
   endtask
   task automatic start();
      sda_drv = 1'b1;
      hw(6);
      scl = 1'b1;
      hw(6);
      sda_drv = 1'b0;
      hw(6);
      scl = 1'b0;
   endtask
   task automatic wbyte(input logic [7:0] d, output logic nak);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(d[i], r);
      bit_x(1'b1, nak);
   endtask
   task automatic xfer(input logic [6:0] dv, input logic [7:0] a, input logic [15:0] d, input logic rd,
      input int n, output logic [15:0] q, output logic ok);
      logic k;
      logic nk;
      q = 16'h0000;
      start();
      wbyte({dv, 1'b0}, nk);
      wbyte(a, k);
      nk |= k;
      if (rd) begin
         start();
         wbyte({dv, 1'b1}, k);
         nk |= k;
         for (int j = 0; j < n; j++) begin
            for (int i = 7; i >= 0; i--) bit_x(1'b1, q[15 - 8 * j - (7 - i)]);
            bit_x(j == n - 1, k);
         end
      end else begin
         for (int j = 0; j < n; j++) begin
            wbyte(d[15 - 8 * j -: 8], k);
            nk |= k;
         end
      end
      hw(1);
      sda_drv = 1'b0;
      hw(5);
      scl = 1'b1;
      hw(6);
      sda_drv = 1'b1;
      hw(6);
      ok = !nk;
   endtask
endmodule

// ==== sgp_pin_pad.sv ====
// one general-purpose pin: driver, bias controls and input sampling
// assumes pin_i comes from the pad, outside the clock domain
`timescale 1ns/1ps
module sgp_pin_pad import sgp_pkg::*; (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [7:0] cfg,
   input wire logic drive_val,
   input wire logic drives_out,
   input wire logic pin_i,
   output logic pin_o,
   output logic pin_oe,
   output logic pull_up_en,
   output logic pull_down_en,
   output logic level
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic o;
      logic oe;
   } sgp_pad_state_type;
   sgp_pad_state_type q, d;
   logic [1:0] pull;

   always_comb begin
      d = q;
      d.s1 = pin_i;
      d.s2 = q.s1;
      d.o = drive_val;
      d.oe = cfg[SGP_CFG_DRV_BIT] & drives_out;
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   // reserved bias code leaves both resistors off
   assign pull = cfg[SGP_CFG_PULL_LSB +: 2];
   assign pull_up_en = (pull == SGP_PULL_UP);
   assign pull_down_en = (pull == SGP_PULL_DOWN);
   assign level = q.s2 & cfg[SGP_CFG_INBUF_BIT];
   assign pin_o = q.o;
   assign pin_oe = q.oe;
endmodule

// ==== sgp_pkg.sv ====
// constants, state codes and register map of the bus-read and pin block
// assumes a single 10 MHz system clock for every user of the package
package sgp_pkg;
   localparam int SGP_CLK_HZ = 10_000_000;
   localparam logic [6:0] SGP_DEV_ADDR = 7'h5d;
   localparam logic [7:0] SGP_REG_PIN0_CFG = 8'h20;
   localparam logic [7:0] SGP_REG_PIN1_CFG = 8'h21;
   localparam logic [7:0] SGP_REG_PIN2_CFG = 8'h22;
   localparam logic [7:0] SGP_REG_PIN_OUT = 8'h23;
   localparam logic [7:0] SGP_REG_PIN_IN = 8'h24;
   localparam logic [7:0] SGP_REG_STATUS = 8'h25;
   localparam logic [7:0] SGP_CFG_RESET = 8'h00;
   localparam logic [2:0] SGP_OUT_RESET = 3'h0;
   localparam logic [7:0] SGP_PTR_RESET = 8'h00;
   localparam int SGP_CFG_DRV_BIT = 0;
   localparam int SGP_CFG_INBUF_BIT = 1;
   localparam int SGP_CFG_PULL_LSB = 2;
   localparam int SGP_CFG_FUNC_LSB = 4;
   localparam logic [1:0] SGP_PULL_NONE = 2'h0;
   localparam logic [1:0] SGP_PULL_DOWN = 2'h1;
   localparam logic [1:0] SGP_PULL_UP = 2'h2;
   localparam logic [3:0] SGP_BYTE_BITS = 4'h8;
   localparam logic [3:0] SGP_LAST_TX_BIT = 4'h7;
   localparam logic [1:0] SGP_IDX_DATA = 2'h2;
   // pin 0 functions
   localparam logic [3:0] SGP_P0_INPUT = 4'h0;
   localparam logic [3:0] SGP_P0_LOCK = 4'h1;
   localparam logic [3:0] SGP_P0_CLKDET = 4'h2;
   localparam logic [3:0] SGP_P0_POR = 4'h3;
   localparam logic [3:0] SGP_P0_OUTPUT = 4'h4;
   // pin 1 functions, loss of signal for lanes 0..4 from code 3 up
   localparam logic [3:0] SGP_P1_POR = 4'h0;
   localparam logic [3:0] SGP_P1_OUTPUT = 4'h1;
   localparam logic [3:0] SGP_P1_INPUT = 4'h2;
   localparam logic [3:0] SGP_P1_LOS0 = 4'h3;
   localparam logic [3:0] SGP_P1_LOS4 = 4'h7;
   // pin 2 functions
   localparam logic [3:0] SGP_P2_OUTPUT = 4'h0;
   localparam logic [3:0] SGP_P2_INPUT = 4'h1;
   localparam logic [3:0] SGP_P2_SERCLK = 4'h2;
   typedef enum logic [2:0] {
      SGP_IDLE, SGP_RX, SGP_RX_ACK, SGP_TX, SGP_TX_ACK, SGP_IGNORE
   } sgp_bus_state_type;
endpackage

// ==== sgp_smbus_gpio.sv ====
// bus-port register access with chip select and three configurable pins
// assumes the host masters scl/sda through pull-ups; status inputs share sys_clk
`timescale 1ns/1ps
// Summary of operation
// - after read address, device shifts addressed register out msb first
// - host nack ends the read; device releases the data line
// - device answers only while bus port select is high
// - fixed seven-bit address, no address resolution protocol
// - three pins with tristate, buffer disable and pull choices
// - each pin has its own config register, function in upper nibble
// - pin 0: output, input, clock status, clock detect, power-on reset
// - pin 1: power-on reset, output, input, loss of signal lanes 0-4
// - config bits 3:2 choose none, pull-down, pull-up; 11 reserved
// - config bit 1 enables the input buffer
// - config bit 0 enables the output driver, else high impedance
// - pin 0 config 0001 0001 drives pll lock out
// - clock detect status can be routed straight to a pin
// - write address increments after each data byte
// - bytes are eight bits msb first plus acknowledge bit
module sgp_smbus_gpio import sgp_pkg::*; #(
   parameter logic [6:0] DEV_ADDR = SGP_DEV_ADDR,
   parameter int NUM_LANES = 5
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic bus_port_select,
   input wire logic pll_lock,
   input wire logic clk_detect,
   input wire logic por_status,
   input wire logic [NUM_LANES-1:0] lane_los,
   input wire logic ser_clk,
   input wire logic [2:0] gpio_i,
   output logic [2:0] gpio_o,
   output logic [2:0] gpio_oe,
   output logic [2:0] gpio_pull_up,
   output logic [2:0] gpio_pull_down
);
   typedef struct packed {
      logic scl1, scl2, scl3;
      logic sda1, sda2, sda3;
      logic cs1, cs2;
      sgp_bus_state_type st;
      logic [3:0] cnt;
      logic [1:0] idx;
      logic rw;
      logic nack;
      logic [7:0] sh;
      logic [7:0] ptr;
      logic oe;
      logic [2:0][7:0] cfg;
      logic [2:0] out_val;
   } sgp_state_type;

   sgp_state_type q, d;
   logic [2:0] pin_level;
   logic [2:0] src;
   logic [2:0] is_out;
   logic [7:0] rd_data;
   logic scl_rise, scl_fall, start_c, stop_c;
   logic [3:0] f0, f1, f2;

   // only the second sync stage and its delayed copy feed edge detection
   assign scl_rise = q.scl2 & ~q.scl3;
   assign scl_fall = ~q.scl2 & q.scl3;
   assign start_c = q.scl2 & q.scl3 & q.sda3 & ~q.sda2;
   assign stop_c = q.scl2 & q.scl3 & ~q.sda3 & q.sda2;

   assign f0 = q.cfg[0][SGP_CFG_FUNC_LSB +: 4];
   assign f1 = q.cfg[1][SGP_CFG_FUNC_LSB +: 4];
   assign f2 = q.cfg[2][SGP_CFG_FUNC_LSB +: 4];

   always_comb begin
      src = '0;
      is_out = '0;
      unique case (f0)
         SGP_P0_LOCK: begin src[0] = pll_lock; is_out[0] = 1'b1; end
         SGP_P0_CLKDET: begin src[0] = clk_detect; is_out[0] = 1'b1; end
         SGP_P0_POR: begin src[0] = por_status; is_out[0] = 1'b1; end
         SGP_P0_OUTPUT: begin src[0] = q.out_val[0]; is_out[0] = 1'b1; end
         default: begin src[0] = 1'b0; is_out[0] = 1'b0; end
      endcase
      if (f1 >= SGP_P1_LOS0 && f1 <= SGP_P1_LOS4) begin
         src[1] = lane_los[3'(f1 - SGP_P1_LOS0)];
         is_out[1] = 1'b1;
      end else if (f1 == SGP_P1_POR) begin
         src[1] = por_status;
         is_out[1] = 1'b1;
      end else if (f1 == SGP_P1_OUTPUT) begin
         src[1] = q.out_val[1];
         is_out[1] = 1'b1;
      end
      unique case (f2)
         SGP_P2_OUTPUT: begin src[2] = q.out_val[2]; is_out[2] = 1'b1; end
         SGP_P2_SERCLK: begin src[2] = ser_clk; is_out[2] = 1'b1; end
         default: begin src[2] = 1'b0; is_out[2] = 1'b0; end
      endcase
   end

   // input functions leave is_out low so the driver stays off
   for (genvar i = 0; i < 3; i++) begin : g_pin
      sgp_pin_pad u_pad (
         .sys_clk(sys_clk),
         .resetn(resetn),
         .ce(ce),
         .cfg(q.cfg[i]),
         .drive_val(src[i]),
         .drives_out(is_out[i]),
         .pin_i(gpio_i[i]),
         .pin_o(gpio_o[i]),
         .pin_oe(gpio_oe[i]),
         .pull_up_en(gpio_pull_up[i]),
         .pull_down_en(gpio_pull_down[i]),
         .level(pin_level[i])
      );
   end

   always_comb begin
      unique case (q.ptr)
         SGP_REG_PIN0_CFG: rd_data = q.cfg[0];
         SGP_REG_PIN1_CFG: rd_data = q.cfg[1];
         SGP_REG_PIN2_CFG: rd_data = q.cfg[2];
         SGP_REG_PIN_OUT: rd_data = {5'h00, q.out_val};
         SGP_REG_PIN_IN: rd_data = {5'h00, pin_level};
         SGP_REG_STATUS: rd_data = 8'({por_status, clk_detect, pll_lock, lane_los});
         default: rd_data = 8'h00;
      endcase
   end

   always_comb begin
      d = q;
      d.scl1 = scl_i;
      d.scl2 = q.scl1;
      d.scl3 = q.scl2;
      d.sda1 = sda_i;
      d.sda2 = q.sda1;
      d.sda3 = q.sda2;
      d.cs1 = bus_port_select;
      d.cs2 = q.cs1;
      if (!q.cs2 || stop_c) begin
         d.st = SGP_IDLE;
         d.oe = 1'b0;
      end else if (start_c) begin
         d.st = SGP_RX;
         d.cnt = '0;
         d.idx = '0;
         d.oe = 1'b0;
      end else begin
         unique case (q.st)
            SGP_IDLE, SGP_IGNORE: d.oe = 1'b0;
            SGP_RX: begin
               if (scl_rise && q.cnt < SGP_BYTE_BITS) begin
                  d.sh = {q.sh[6:0], q.sda2};
                  d.cnt = q.cnt + 4'h1;
               end else if (scl_fall && q.cnt == SGP_BYTE_BITS) begin
                  d.st = SGP_RX_ACK;
                  d.oe = 1'b1;
                  if (q.idx == 2'h0) begin
                     if (q.sh[7:1] == DEV_ADDR) begin
                        d.rw = q.sh[0];
                     end else begin
                        d.st = SGP_IGNORE;
                        d.oe = 1'b0;
                     end
                  end else if (q.idx == 2'h1) begin
                     d.ptr = q.sh;
                  end else begin
                     unique case (q.ptr)
                        SGP_REG_PIN0_CFG: d.cfg[0] = q.sh;
                        SGP_REG_PIN1_CFG: d.cfg[1] = q.sh;
                        SGP_REG_PIN2_CFG: d.cfg[2] = q.sh;
                        SGP_REG_PIN_OUT: d.out_val = q.sh[2:0];
                        default: d.out_val = q.out_val;
                     endcase
                     d.ptr = q.ptr + 8'h01;
                  end
               end
            end
            SGP_RX_ACK: begin
               if (scl_fall) begin
                  d.cnt = '0;
                  if (q.idx == 2'h0 && q.rw) begin
                     d.st = SGP_TX;
                     d.sh = rd_data;
                     d.oe = ~rd_data[7];
                     d.ptr = q.ptr + 8'h01;
                  end else begin
                     d.st = SGP_RX;
                     d.oe = 1'b0;
                     d.idx = (q.idx == SGP_IDX_DATA) ? SGP_IDX_DATA : q.idx + 2'h1;
                  end
               end
            end
            SGP_TX: begin
               if (scl_fall) begin
                  if (q.cnt == SGP_LAST_TX_BIT) begin
                     d.st = SGP_TX_ACK;
                     d.oe = 1'b0;
                     d.cnt = '0;
                     d.nack = 1'b1;
                  end else begin
                     d.sh = {q.sh[6:0], 1'b0};
                     d.oe = ~q.sh[6];
                     d.cnt = q.cnt + 4'h1;
                  end
               end
            end
            SGP_TX_ACK: begin
               if (scl_rise) begin
                  d.nack = q.sda2;
               end else if (scl_fall) begin
                  if (!q.nack) begin
                     d.st = SGP_TX;
                     d.sh = rd_data;
                     d.oe = ~rd_data[7];
                     d.ptr = q.ptr + 8'h01;
                  end else begin
                     d.st = SGP_IGNORE;
                     d.oe = 1'b0;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
         q.scl1 <= 1'b1;
         q.scl2 <= 1'b1;
         q.scl3 <= 1'b1;
         q.sda1 <= 1'b1;
         q.sda2 <= 1'b1;
         q.sda3 <= 1'b1;
         q.st <= SGP_IDLE;
         q.ptr <= SGP_PTR_RESET;
         q.cfg <= {3{SGP_CFG_RESET}};
         q.out_val <= SGP_OUT_RESET;
      end else if (ce) begin
         q <= d;
      end
   end

   // open drain: only ever pulls low
   assign sda_o = 1'b0;
   assign sda_oe = q.oe;
endmodule

// ==== sgp_smbus_gpio_assertions.sv ====
// port-level timing checks for the bus port and pin controls
// assumes one clock domain and active-low async resetn
`timescale 1ns/1ps
module sgp_smbus_gpio_checker (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_oe,
   input wire logic bus_port_select,
   input wire logic [2:0] gpio_oe,
   input wire logic [2:0] gpio_pull_up,
   input wire logic [2:0] gpio_pull_down
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence drive_start;
      $rose(sda_oe);
   endsequence
   sequence clk_high_held;
      (scl_i && bus_port_select) [*6];
   endsequence
   sel_idle_a: assert property (!bus_port_select [*4] |-> !sda_oe) else $error("sda driven unselected");
   ack_edge_a: assert property (drive_start |-> !$past(scl_i) && !$past(scl_i, 2)) else $error("drive in scl high");
   ack_hold_a: assert property (drive_start |-> sda_oe [*4]) else $error("drive too short");
   data_stable_a: assert property (clk_high_held |-> $stable(sda_oe)) else $error("sda moved in scl high");
   stop_release_a: assert property (scl_i && $rose(sda_i) |-> ##[0:4] !sda_oe) else $error("sda held after stop");
   bias_excl_a: assert property (!(|(gpio_pull_up & gpio_pull_down))) else $error("both pulls on");
   bias_src_a: assert property ($changed(gpio_pull_up) || $changed(gpio_pull_down) |->
      ##[0:1] (sda_oe || $past(sda_oe))) else $error("bias moved without write");
   oe_src_a: assert property ($changed(gpio_oe) |->
      ##[0:1] (sda_oe || $past(sda_oe) || $past(sda_oe, 2))) else $error("driver moved without write");
endmodule
bind sgp_smbus_gpio sgp_smbus_gpio_checker chk_u (.*);

// ==== smbus_read_and_gpio_pins_test.sv ====
// self-checking bench: register reads, writes and pin functions
// assumes the host model and a 10 MHz system clock
`timescale 1ns/1ps
module smbus_read_and_gpio_pins_test import sgp_pkg::*;;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic sel = 1'b1;
   logic [8:0] stat = 9'h000;
   logic [2:0] gpio_i = 3'h0;
   wire logic scl, sda_drv, sda_oe, sda_o, sda;
   wire logic [2:0] g_o, g_oe, g_pu, g_pd;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   assign sda = sda_drv && !(sda_oe && !sda_o);
   always #50 sys_clk = ~sys_clk;
   sgp_smbus_gpio dut_u (.sys_clk(sys_clk), .resetn(resetn), .ce(1'b1), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .bus_port_select(sel), .pll_lock(stat[5]), .clk_detect(stat[6]), .por_status(stat[7]),
      .lane_los(stat[4:0]), .ser_clk(stat[8]), .gpio_i(gpio_i), .gpio_o(g_o), .gpio_oe(g_oe),
      .gpio_pull_up(g_pu), .gpio_pull_down(g_pd));
   sgp_host_model host_u (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
   task automatic w(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic xf(input logic [6:0] dv, input logic [7:0] a, input logic [15:0] d, input logic rd, input int n,
      input logic ok_exp, input logic [15:0] exp);
      logic [15:0] q;
      logic ok;
      host_u.xfer(dv, a, d, rd, n, q, ok);
      chk({15'h0, ok}, {15'h0, ok_exp});
      if (rd && ok_exp) chk(q, exp);
   endtask
   task automatic t_reset();
      xf(SGP_DEV_ADDR, SGP_REG_PIN0_CFG, 16'h0, 1'b1, 2, 1'b1, {SGP_CFG_RESET, SGP_CFG_RESET});
      chk({13'h0, g_oe}, 16'h0000);
      $display("reset test done");
   endtask
   task automatic t_funcs();
      logic [7:0] a;
      logic [7:0] c;
      int p;
      int b;
      for (int k = 0; k < 10; k++) begin
         a = (k < 3) ? SGP_REG_PIN0_CFG : (k < 9) ? SGP_REG_PIN1_CFG : SGP_REG_PIN2_CFG;
         c = (k < 3) ? {k[3:0] + 4'h1, 4'h1} : (k == 3) ? 8'h01 : (k < 9) ? {k[3:0] - 4'h1, 4'h1} : 8'h21;
         p = (k < 3) ? 0 : (k < 9) ? 1 : 2;
         b = (k < 3) ? k + 5 : (k == 3) ? 7 : (k < 9) ? k - 4 : 8;
         xf(SGP_DEV_ADDR, a, {c, 8'h00}, 1'b0, 1, 1'b1, 16'h0);
         stat = 9'h001 << b;
         w(4);
         chk({14'h0, g_oe[p], g_o[p]}, 16'h0003);
         stat = 9'h000;
         w(4);
         chk({15'h0, g_o[p]}, 16'h0000);
      end
      $display("function test done");
   endtask
   task automatic t_bias();
      xf(SGP_DEV_ADDR, SGP_REG_PIN1_CFG, 16'h1905, 1'b0, 2, 1'b1, 16'h0);
      xf(SGP_DEV_ADDR, SGP_REG_PIN_OUT, 16'h0600, 1'b0, 1, 1'b1, 16'h0);
      w(3);
      chk({10'h0, g_pu, g_pd}, {10'h0, 3'h2, 3'h4});
      chk({12'h0, g_oe[2:1], g_o[2:1]}, 16'h000f);
      xf(SGP_DEV_ADDR, SGP_REG_PIN1_CFG, 16'h0, 1'b1, 2, 1'b1, 16'h1905);
      xf(SGP_DEV_ADDR, SGP_REG_PIN1_CFG, 16'h1d00, 1'b0, 1, 1'b1, 16'h0);
      w(3);
      chk({14'h0, g_pu[1], g_pd[1]}, 16'h0000);
      $display("bias test done");
   endtask
   task automatic t_input();
      xf(SGP_DEV_ADDR, SGP_REG_PIN1_CFG, 16'h2212, 1'b0, 2, 1'b1, 16'h0);
      gpio_i = 3'h7;
      w(6);
      chk({14'h0, g_oe[2:1]}, 16'h0000);
      xf(SGP_DEV_ADDR, SGP_REG_PIN_IN, 16'h0, 1'b1, 1, 1'b1, 16'h0600);
      gpio_i = 3'h2;
      w(6);
      xf(SGP_DEV_ADDR, SGP_REG_PIN_IN, 16'h0, 1'b1, 1, 1'b1, 16'h0200);
      $display("input test done");
   endtask
   task automatic t_select();
      sel = 1'b0;
      w(6);
      xf(SGP_DEV_ADDR, SGP_REG_PIN0_CFG, 16'h0, 1'b1, 1, 1'b0, 16'h0);
      sel = 1'b1;
      w(6);
      xf(SGP_DEV_ADDR ^ 7'h01, SGP_REG_PIN0_CFG, 16'h0, 1'b1, 1, 1'b0, 16'h0);
      xf(SGP_DEV_ADDR, SGP_REG_PIN0_CFG, 16'h0, 1'b1, 1, 1'b1, 16'h3100);
      chk({15'h0, sda_oe}, 16'h0000);
      $display("select test done");
   endtask
   task automatic conclude();
      $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ceiling well above the roughly 9000 cycles of traffic
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         conclude();
      end
   end
   initial begin
      w(10);
      resetn = 1'b1;
      w(3);
      t_reset();
      t_funcs();
      t_bias();
      t_input();
      t_select();
      conclude();
   end
endmodule
